/* File: verilog/wdrst_seq.sv */
// Watchdog reset and initialisation sequencer with AXI4-Lite registers
//
// Summary of operation
// - Normal-mode expiry gives full reset, sets expiry flag
// - Full reset waits power-on delay before running
// - Sleep/idle expiry clears only PC and SP
// - Wake settle time depends on clock source
// - Illegal enable key causes software reset
// - Legal enable key keeps watchdog enabled
// - Illegal key reset after three slow-oscillator edges
// - Key reset sets key flag after reset completes
// - Control register holds key and period fields
// - Low-voltage reset leaves both mode flags unchanged
// - Normal-mode watchdog reset keeps powerdown flag
// - Sleep/idle watchdog reset sets both flags
// - Power-on reset disables all interrupts
// - Power-on reset clears watchdog counter, restarts it
// - Power-on reset switches timers off
// - Power-on reset makes pins inputs, analog converter
// - Power-on reset zeroes PC, SP to stack top
// - Clear instruction, halt, key reset clear counter
// - Software may clear cause flags, never set
`timescale 1ns/1ps
`default_nettype none
module wdrst_seq
  import wdrst_pkg::*;
#(
  parameter int POR_DELAY = POWER_ON_DELAY_CYC
) (
  input  wire logic        core_clk,        // System clock, 50 MHz
  input  wire logic        rstn,            // Power-on reset, active low
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [7:0]  s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  // Core and watchdog side
  input  wire logic        wdt_expire,      // Watchdog overflow pulse
  input  wire logic        lvr_event,       // Low-voltage reset pulse
  input  wire logic        low_power_mode,  // Core in sleep or idle
  input  wire logic        clr_wdt_instr,   // Clear-watchdog instruction pulse
  input  wire logic        halt_instr,      // Halt instruction pulse
  input  wire logic [1:0]  clk_src,         // System clock source select
  input  wire logic        slow_osc_clk,    // Slow internal oscillator pin
  output logic             wdt_enable,      // Watchdog counting enabled
  output logic [2:0]       wdt_period_sel,  // Watchdog period select
  output logic             wdt_clear,       // Watchdog counter clear pulse
  output logic             core_hold,       // Core stalled
  output logic             full_reset,      // Whole-device reset active
  output logic             pc_sp_clear,     // PC and SP to zero pulse
  output logic             init_apply,      // Power-on state being applied
  output logic             intr_disable,    // All interrupt enables cleared
  output logic             timers_off,      // All timer modules off
  output logic             io_all_input,    // All pins as inputs
  output logic             analog_in_sel,   // Analog inputs to converter
  output logic             sp_to_top        // Stack pointer to stack top
);

  if (POR_DELAY < 1 || POR_DELAY >= (1 << TIMER_W)) begin : g_por_chk
    $error("wdrst_seq: bad POR_DELAY");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  wdrst_state_e       state_r;
  wdrst_state_e       state_nxt;
  logic [7:0]         wdt_ctrl_r;
  logic               expiry_flag_r;
  logic               pdown_flag_r;
  logic               key_flag_r;
  logic               cause_key_r;
  logic               slow_s1_r, slow_s2_r, slow_s3_r;
  logic [1:0]         deb_cnt_r;
  logic               key_trip;
  logic               key_legal;
  logic               tmr_load;
  logic [TIMER_W-1:0] tmr_val;
  logic               tmr_busy;
  logic               tmr_done;
  logic               full_evt;
  logic               part_evt;
  logic               aw_held_r, w_held_r;
  logic [7:0]         aw_addr_r;
  logic [7:0]         w_data_r;
  logic               w_lane0_r;
  logic               wr_fire;

  function automatic logic key_ok(input logic [4:0] k);
    key_ok = (k == KEY_VALID_A) || (k == KEY_VALID_B);
  endfunction : key_ok

  function automatic logic [TIMER_W-1:0] settle_cycles(input logic [1:0] src);
    case (src)
      CLKSRC_XTAL: settle_cycles = TIMER_W'(SETTLE_XTAL_CYC);
      CLKSRC_SLOW: settle_cycles = TIMER_W'(SETTLE_SLOW_CYC);
      default:     settle_cycles = TIMER_W'(SETTLE_FAST_CYC);
    endcase
  endfunction : settle_cycles

  // ----------------------------------------------------------------------
  // Key check and slow-oscillator debounce
  // ----------------------------------------------------------------------
  assign key_legal = key_ok(wdt_ctrl_r[KEY_MSB:KEY_LSB]);
  assign wdt_enable = key_legal && (state_r == ST_RUN || state_r == ST_SETTLE);
  assign wdt_period_sel = wdt_ctrl_r[PERIOD_MSB:0];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      slow_s3_r <= 1'b0;
    end else begin
      slow_s1_r <= slow_osc_clk;
      slow_s2_r <= slow_s1_r;
      slow_s3_r <= slow_s2_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      deb_cnt_r <= 2'h0;
    end else if (key_legal || state_r != ST_RUN) begin
      deb_cnt_r <= 2'h0;
    end else if (slow_s2_r && !slow_s3_r && deb_cnt_r != 2'(KEY_DEBOUNCE_EDGES)) begin
      deb_cnt_r <= deb_cnt_r + 2'h1;
    end
  end

  assign key_trip = (deb_cnt_r == 2'(KEY_DEBOUNCE_EDGES)) && !key_legal;

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  assign full_evt = lvr_event || (state_r == ST_RUN && (key_trip ||
                    (wdt_expire && !low_power_mode)));
  assign part_evt = state_r == ST_RUN && wdt_expire && low_power_mode;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT:   state_nxt = ST_DELAY;
      ST_DELAY:  if (tmr_done) state_nxt = ST_RUN;
      ST_RUN:    if (part_evt) state_nxt = ST_SETTLE;
      ST_SETTLE: if (tmr_done) state_nxt = ST_RUN;
      default:   state_nxt = ST_INIT;
    endcase
    if (full_evt) state_nxt = ST_INIT;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cause_key_r <= 1'b0;
    end else if (full_evt) begin
      cause_key_r <= key_trip && state_r == ST_RUN && !lvr_event;
    end else if (state_r == ST_DELAY && tmr_done) begin
      cause_key_r <= 1'b0;
    end
  end

  assign tmr_load = (state_r == ST_INIT) || part_evt;
  assign tmr_val  = (state_r == ST_INIT) ? TIMER_W'(POR_DELAY) : settle_cycles(clk_src);

  wdrst_timer #(
    .W (TIMER_W)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  assign full_reset    = (state_r == ST_INIT) || (state_r == ST_DELAY);
  assign core_hold     = (state_r != ST_RUN);
  assign init_apply    = full_reset;
  assign intr_disable  = full_reset;
  assign timers_off    = full_reset;
  assign io_all_input  = full_reset;
  assign analog_in_sel = full_reset;
  assign sp_to_top     = full_reset;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_sp_clear <= 1'b0;
      wdt_clear   <= 1'b0;
    end else begin
      pc_sp_clear <= part_evt || (state_nxt == ST_INIT);
      wdt_clear   <= (state_nxt == ST_INIT) || clr_wdt_instr || halt_instr;
    end
  end

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      expiry_flag_r <= 1'b0;
    end else if (state_r == ST_RUN && wdt_expire) begin
      expiry_flag_r <= 1'b1;
    end else if (clr_wdt_instr || halt_instr) begin
      expiry_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pdown_flag_r <= 1'b0;
    end else if (halt_instr || part_evt) begin
      pdown_flag_r <= 1'b1;
    end else if (clr_wdt_instr) begin
      pdown_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_flag_r <= 1'b0;
    end else if (state_r == ST_DELAY && tmr_done && cause_key_r) begin
      key_flag_r <= 1'b1;
    end else if (wr_fire && aw_addr_r == ADDR_RESET_FLAG && w_lane0_r &&
                 !w_data_r[RFLAG_KEY_BIT]) begin
      key_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog control register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_ctrl_r <= WDT_CTRL_RESET;
    end else if (full_evt) begin
      wdt_ctrl_r <= WDT_CTRL_RESET;
    end else if (wr_fire && aw_addr_r == ADDR_WDT_CTRL && w_lane0_r) begin
      wdt_ctrl_r <= w_data_r;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      w_held_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r  <= 1'b1;
      w_data_r  <= s_axi_wdata[7:0];
      w_lane0_r <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_r[7:2] <= ADDR_RESET_FLAG[7:2] && aw_addr_r[1:0] == 2'h0)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        ADDR_WDT_CTRL:   s_axi_rdata <= {24'h00_0000, wdt_ctrl_r};
        ADDR_STATUS:     s_axi_rdata <= {30'h0000_0000, pdown_flag_r, expiry_flag_r};
        ADDR_RESET_FLAG: s_axi_rdata <= {31'h0000_0000, key_flag_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : wdrst_seq
`default_nettype wire

/* File: verilog/wdrst_pkg.sv */
// Constants for the watchdog reset and initialisation sequencer
package wdrst_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam real CLK_PERIOD_NS      = 20.0;
  localparam real POWER_ON_DELAY_MS  = 16.7;
  localparam int  POWER_ON_DELAY_CYC = $rtoi(POWER_ON_DELAY_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  SETTLE_FAST_CYC    = 16;
  localparam int  SETTLE_XTAL_CYC    = 128;
  localparam int  SETTLE_SLOW_CYC    = 2;
  localparam int  KEY_DEBOUNCE_EDGES = 3;
  localparam int  TIMER_W            = 20;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_WDT_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_RESET_FLAG = 8'h08;

  localparam logic [7:0] WDT_CTRL_RESET  = 8'h53;
  localparam int         KEY_MSB         = 7;
  localparam int         KEY_LSB         = 3;
  localparam int         PERIOD_MSB      = 2;
  localparam logic [4:0] KEY_VALID_A     = 5'h15;
  localparam logic [4:0] KEY_VALID_B     = 5'h0A;

  localparam int         STAT_EXPIRY_BIT = 0;
  localparam int         STAT_PDOWN_BIT  = 1;
  localparam int         RFLAG_KEY_BIT   = 0;

  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------------
  // Clock source select and sequencer states
  // ----------------------------------------------------------------------
  localparam logic [1:0] CLKSRC_FAST = 2'h0;
  localparam logic [1:0] CLKSRC_XTAL = 2'h1;
  localparam logic [1:0] CLKSRC_SLOW = 2'h2;

  typedef enum logic [3:0] {
    ST_INIT   = 4'b0001,
    ST_DELAY  = 4'b0010,
    ST_RUN    = 4'b0100,
    ST_SETTLE = 4'b1000
  } wdrst_state_e;

endpackage : wdrst_pkg

/* File: verilog/wdrst_timer.sv */
// Loadable down counter used for reset and wake delays
`timescale 1ns/1ps
`default_nettype none
module wdrst_timer #(
  parameter int W = 20
) (
  input  wire logic         core_clk,  // System clock
  input  wire logic         rstn,      // Async reset, active low
  input  wire logic         load,      // Start a new count
  input  wire logic [W-1:0] load_val,  // Cycles to count, at least 1
  output logic              busy,      // Count in progress
  output logic              done       // One-cycle pulse at end
);

  logic [W-1:0] cnt_r;

  if (W < 2) begin : g_w_chk
    $error("wdrst_timer: W too small");
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
    end else begin
      done <= !load && (cnt_r == W'(1));
    end
  end

  assign busy = (cnt_r != '0);

endmodule : wdrst_timer
`default_nettype wire

/* File: tb/wdrst_checker.sv */
// Port-level assertion checker for the watchdog reset sequencer
`timescale 1ns/1ps
`default_nettype none
module wdrst_checker #(
  parameter int POR_DELAY = 20
) (
  input wire logic core_clk,        // Clock
  input wire logic rstn,            // Reset
  input wire logic wdt_expire,      // Expiry
  input wire logic lvr_event,       // Low voltage
  input wire logic low_power_mode,  // Sleep
  input wire logic clr_wdt_instr,   // Clear
  input wire logic halt_instr,      // Halt
  input wire logic wdt_enable,      // Enabled
  input wire logic wdt_clear,       // Counter clear
  input wire logic core_hold,       // Stall
  input wire logic full_reset,      // Full reset
  input wire logic pc_sp_clear,     // Partial clear
  input wire logic init_apply,      // Init state
  input wire logic intr_disable,    // Interrupts off
  input wire logic timers_off,      // Timers off
  input wire logic io_all_input,    // Pins in
  input wire logic analog_in_sel,   // Analog sel
  input wire logic sp_to_top        // Stack top
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] fr_cnt_r;
  // Cycles spent in full reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) fr_cnt_r <= '0;
    else if (full_reset) fr_cnt_r <= fr_cnt_r + 32'h0000_0001;
    else fr_cnt_r <= '0;
  end
  init_outs_a:
    assert property ({intr_disable, timers_off, io_all_input, analog_in_sel, sp_to_top,
      init_apply} == {6{full_reset}}) else $error("Init outputs differ from full reset");
  por_wait_a:
    assert property ($fell(full_reset) |-> fr_cnt_r >= POR_DELAY)
      else $error("Full reset released too early");
  hold_full_a:
    assert property (full_reset |-> core_hold) else $error("Core runs during reset");
  full_exp_a:
    assert property (!core_hold && wdt_expire && !low_power_mode |=> full_reset)
      else $error("Normal expiry gave no full reset");
  part_hold_a:
    assert property (!core_hold && wdt_enable && wdt_expire && low_power_mode && !lvr_event
      |=> core_hold && !full_reset) else $error("Sleep expiry handled wrongly");
  part_clr_a:
    assert property (!core_hold && wdt_enable && wdt_expire && low_power_mode && !lvr_event
      |-> ##[1:2] pc_sp_clear) else $error("No PC and SP clear");
  lvr_full_a:
    assert property (lvr_event |=> full_reset) else $error("Low voltage gave no reset");
  clr_pulse_a:
    assert property (!core_hold && (clr_wdt_instr || halt_instr) |-> ##[1:2] wdt_clear)
      else $error("Counter clear missing");
  en_run_a:
    assert property (wdt_enable |-> !full_reset) else $error("Watchdog enabled in reset");
  cover property ($rose(full_reset));
  cover property (pc_sp_clear && !full_reset);
  cover property (wdt_clear && !full_reset);
endmodule : wdrst_checker
bind wdrst_seq wdrst_checker #(.POR_DELAY(POR_DELAY)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .wdt_expire(wdt_expire), .lvr_event(lvr_event),
  .low_power_mode(low_power_mode), .clr_wdt_instr(clr_wdt_instr), .halt_instr(halt_instr),
  .wdt_enable(wdt_enable), .wdt_clear(wdt_clear), .core_hold(core_hold),
  .full_reset(full_reset), .pc_sp_clear(pc_sp_clear), .init_apply(init_apply),
  .intr_disable(intr_disable), .timers_off(timers_off), .io_all_input(io_all_input),
  .analog_in_sel(analog_in_sel), .sp_to_top(sp_to_top));
`default_nettype wire

/* File: tb/wdrst_seq_tb.sv */
// Self-checking testbench for the watchdog reset sequencer
`timescale 1ns/1ps
`default_nettype none
module wdrst_seq_tb;
  import wdrst_pkg::*;
  localparam int POR = 20;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, slow_div;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, clk_src;
  logic wdt_expire, lvr_event, low_power_mode, clr_wdt_instr, halt_instr, slow_osc_clk;
  logic wdt_enable, wdt_clear, core_hold, full_reset, pc_sp_clear, init_apply;
  logic intr_disable, timers_off, io_all_input, analog_in_sel, sp_to_top;
  logic [2:0] wdt_period_sel;
  int fails, samples_checked, cyc;
  wdrst_seq #(.POR_DELAY(POR)) dut (
    .core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wdt_expire(wdt_expire), .lvr_event(lvr_event), .low_power_mode(low_power_mode),
    .clr_wdt_instr(clr_wdt_instr), .halt_instr(halt_instr), .clk_src(clk_src),
    .slow_osc_clk(slow_osc_clk), .wdt_enable(wdt_enable), .wdt_period_sel(wdt_period_sel),
    .wdt_clear(wdt_clear), .core_hold(core_hold), .full_reset(full_reset),
    .pc_sp_clear(pc_sp_clear), .init_apply(init_apply), .intr_disable(intr_disable),
    .timers_off(timers_off), .io_all_input(io_all_input), .analog_in_sel(analog_in_sel),
    .sp_to_top(sp_to_top));
  // ------------------------------------------------------------------
  // Clocks and run limit
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Slow oscillator, period of 16 core cycles
  always @(posedge core_clk) begin
    slow_div <= slow_div + 8'h01;
    slow_osc_clk <= slow_div[3];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, e);
  endtask : rdc
  // One-cycle event: 0 expiry, 1 low voltage, 2 clear, 3 halt
  task automatic pulse(input int k);
    @(posedge core_clk);
    {wdt_expire, lvr_event, clr_wdt_instr, halt_instr} <= 4'h8 >> k;
    @(posedge core_clk);
    {wdt_expire, lvr_event, clr_wdt_instr, halt_instr} <= 4'h0;
  endtask : pulse
  task automatic wait_hold(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (core_hold === 1'b1 && n < 3000);
    @(posedge core_clk);
  endtask : wait_hold
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_por;
    int n;
    check(32'({intr_disable, timers_off, io_all_input, analog_in_sel, sp_to_top,
               init_apply}), 32'h0000_003F);
    rstn <= 1'b1;
    wait_hold(n);
    check(32'(n >= POR && n <= POR + 4), ONE);
    rdc(ADDR_WDT_CTRL, 32'h0000_0053);
    rdc(ADDR_STATUS, 32'h0);
    check(32'({wdt_enable, wdt_period_sel}), 32'h0000_000B);
  endtask : t_por
  task automatic t_ctrl;
    wr(ADDR_WDT_CTRL, 32'h0000_0055);
    rdc(ADDR_WDT_CTRL, 32'h0000_0055);
    check(32'({wdt_enable, wdt_period_sel}), 32'h0000_000D);
    wr(ADDR_WDT_CTRL, 32'h0000_FFAA);
    rdc(ADDR_WDT_CTRL, 32'h0000_00AA);
    check(32'({wdt_enable, wdt_period_sel}), 32'h0000_000A);
  endtask : t_ctrl
  task automatic t_partial;
    int n;
    int exp_c [3] = '{SETTLE_FAST_CYC, SETTLE_XTAL_CYC, SETTLE_SLOW_CYC};
    low_power_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      clk_src <= 2'(i);
      pulse(0);
      wait_hold(n);
      check(32'(n >= exp_c[i] && n <= exp_c[i] + 3), ONE);
      rdc(ADDR_STATUS, 32'h0000_0003);
      rdc(ADDR_WDT_CTRL, 32'h0000_00AA);
      pulse(2);
      rdc(ADDR_STATUS, 32'h0);
    end
    low_power_mode <= 1'b0;
  endtask : t_partial
  task automatic t_resets;
    int n;
    pulse(3);
    pulse(1);
    wait_hold(n);
    check(32'(n >= POR + 1 && n <= POR + 4), ONE);
    rdc(ADDR_STATUS, 32'h0000_0002);
    wr(ADDR_WDT_CTRL, 32'h0000_0055);
    pulse(0);
    wait_hold(n);
    check(32'(n >= POR + 1 && n <= POR + 4), ONE);
    rdc(ADDR_STATUS, 32'h0000_0003);
    rdc(ADDR_WDT_CTRL, 32'h0000_0053);
    pulse(2);
  endtask : t_resets
  task automatic t_key;
    int n;
    wr(ADDR_WDT_CTRL, 32'h0000_0013);
    wr(ADDR_WDT_CTRL, 32'h0000_0053);
    repeat (60) @(posedge core_clk);
    rdc(ADDR_RESET_FLAG, 32'h0);
    wr(ADDR_WDT_CTRL, 32'h0000_0013);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (full_reset !== 1'b1 && n < 200);
    @(posedge core_clk);
    check(32'(n >= 33 && n <= 52), ONE);
    wait_hold(n);
    rdc(ADDR_RESET_FLAG, ONE);
    wr(ADDR_RESET_FLAG, ONE);
    rdc(ADDR_RESET_FLAG, ONE);
    wr(ADDR_RESET_FLAG, 32'h0);
    rdc(ADDR_RESET_FLAG, 32'h0);
    wr(ADDR_STATUS, 32'h0000_0003);
    rdc(ADDR_STATUS, 32'h0);
  endtask : t_key
  task automatic t_map;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h0C, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(RESP_SLVERR));
  endtask : t_map
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    {wdt_expire, lvr_event, clr_wdt_instr, halt_instr, low_power_mode} = 5'h00;
    {slow_div, slow_osc_clk, cyc, fails, samples_checked} = '0;
    clk_src = CLKSRC_FAST;
    rstn = 1'b0;
    repeat (6) @(posedge core_clk);
    t_por();
    t_ctrl();
    t_partial();
    t_resets();
    t_key();
    t_map();
    print_verdict();
  end
endmodule : wdrst_seq_tb
`default_nettype wire
